/* core/col_drv_pkg.sv */
// package of constants and types for the 80-column lcd driver
`default_nettype none
package col_drv_pkg;
    localparam int unsigned NUM_COLS = 80;
    localparam int unsigned NIB_W = 4;
    localparam int unsigned NIBS_PER_LINE = NUM_COLS / NIB_W;
    localparam int unsigned NIB_CNT_W = 5;
    localparam logic [NIB_CNT_W-1:0] NIB_LAST = 5'h13;
    localparam int unsigned BUF_DEPTH = 2;
    // drive level codes per column
    typedef enum logic [1:0] {
        level_sel_pos,
        level_nonsel_pos,
        level_nonsel_neg,
        level_sel_neg
    } level_type;
endpackage
`default_nettype wire

/* core/nibble_buf.sv */
// two-entry valid/ready buffer for pixel nibbles
`default_nettype none
module nibble_buf
    import col_drv_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [NIB_W-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [NIB_W-1:0] o_data
);
    logic [NIB_W-1:0] mem_q [BUF_DEPTH];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    // handshake terms
    assign o_ready = (count_q != 2'h2);
    assign o_valid = (count_q != 2'h0);
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign o_data = mem_q[rd_ptr_q];

    // storage
    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_q[wr_ptr_q] <= i_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // a word offered while full would be lost
    AST_NO_OVERFLOW: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_valid |-> o_ready)
        else $error("nibble offered while buffer full");
endmodule
`default_nettype wire

/* core/lcd_column_driver_80ch.sv */
// 80-column lcd driver: nibble capture, line latch and level select
`default_nettype none
module lcd_column_driver_80ch
    import col_drv_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_line_strobe,
    input wire logic i_nibble_strobe,
    input wire logic [NIB_W-1:0] i_pixel_nibble,
    input wire logic i_fill_direction,
    input wire logic i_enable_n,
    input wire logic i_blank_n,
    input wire logic i_ac_phase,
    output logic o_carry_n,
    output logic o_nib_ready,
    output logic [2*NUM_COLS-1:0] o_column_drive
);
    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers, two flops each
    logic [8:0] s1_q;
    logic [8:0] s2_q;
    logic [8:0] pins;
    assign pins = {i_line_strobe, i_nibble_strobe, i_pixel_nibble, i_fill_direction,
        i_enable_n, i_blank_n};
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            // strobes idle low, so no false edge after reset
            s1_q <= 9'h07f;
            s2_q <= 9'h07f;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
        end
    end
    logic line_s;
    logic nib_s;
    logic [NIB_W-1:0] data_s;
    logic dir_s;
    logic en_n_s;
    logic blank_n_s;
    assign {line_s, nib_s, data_s, dir_s, en_n_s, blank_n_s} = s2_q;

    logic phase_s1_q;
    logic phase_s2_q;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            phase_s1_q <= 1'b0;
            phase_s2_q <= 1'b0;
        end else begin
            phase_s1_q <= i_ac_phase;
            phase_s2_q <= phase_s1_q;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // falling edge detection on synchronised strobes
    logic line_d1_q;
    logic nib_d1_q;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            line_d1_q <= 1'b0;
            nib_d1_q <= 1'b0;
        end else begin
            line_d1_q <= line_s;
            nib_d1_q <= nib_s;
        end
    end
    logic line_fall;
    logic nib_fall;
    assign line_fall = line_d1_q && !line_s;
    assign nib_fall = nib_d1_q && !nib_s;

    //////////////////////////////////////////////////////////////////////////
    // capture gating: enabled and row not yet full
    logic full_q;
    logic cap_req;
    assign cap_req = nib_fall && !en_n_s && !full_q;

    logic [NIB_W-1:0] nib_q;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            nib_q <= 4'h0;
        end else if (cap_req) begin
            nib_q <= data_s;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // buffer between capture and row placement
    logic buf_valid;
    logic buf_ready;
    logic [NIB_W-1:0] buf_data;
    logic place_ready;
    logic cap_valid_q;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cap_valid_q <= 1'b0;
        end else begin
            cap_valid_q <= cap_req;
        end
    end
    nibble_buf u_buf (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_valid(cap_valid_q),
        .o_ready(buf_ready),
        .i_data(nib_q),
        .o_valid(buf_valid),
        .i_ready(place_ready),
        .o_data(buf_data)
    );
    assign o_nib_ready = buf_ready;

    //////////////////////////////////////////////////////////////////////////
    // nibble counting and carry
    logic [NIB_CNT_W-1:0] cap_cnt_q;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            cap_cnt_q <= '0;
            full_q <= 1'b0;
        end else if (line_fall) begin
            // a capture in the strobe cycle counts for the new row
            cap_cnt_q <= cap_req ? 5'h01 : 5'h00;
            full_q <= 1'b0;
        end else if (cap_req) begin
            if (cap_cnt_q == NIB_LAST) begin
                full_q <= 1'b1;
            end
            cap_cnt_q <= cap_cnt_q + 5'h01;
        end
    end
    assign o_carry_n = ~full_q;

    //////////////////////////////////////////////////////////////////////////
    // row placement from buffer
    logic [NUM_COLS-1:0] row_q;
    logic [NIB_CNT_W-1:0] slot_q;
    logic place;
    assign place_ready = !line_fall;
    assign place = buf_valid && place_ready;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            row_q <= '0;
            slot_q <= '0;
        end else if (line_fall) begin
            slot_q <= '0;
        end else if (place) begin
            for (int i = 0; i < NIBS_PER_LINE; i++) begin
                for (int b = 0; b < NIB_W; b++) begin
                    if (!dir_s && slot_q == NIB_CNT_W'(i)) begin
                        row_q[i*NIB_W+b] <= buf_data[b];
                    end
                    if (dir_s && slot_q == NIB_CNT_W'(i)) begin
                        row_q[NUM_COLS-1-(i*NIB_W+b)] <= buf_data[b];
                    end
                end
            end
            slot_q <= slot_q + 5'h01;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // line latch on line strobe
    logic [NUM_COLS-1:0] line_q;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            line_q <= '0;
        end else if (line_fall) begin
            line_q <= row_q;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // level selection per column, registered
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_column_drive <= '0;
        end else begin
            for (int c = 0; c < NUM_COLS; c++) begin
                if (!blank_n_s) begin
                    o_column_drive[2*c +: 2] <= level_sel_pos;
                end else if (!phase_s2_q) begin
                    o_column_drive[2*c +: 2] <= line_q[c] ? level_sel_pos : level_nonsel_pos;
                end else begin
                    o_column_drive[2*c +: 2] <= line_q[c] ? level_sel_neg : level_nonsel_neg;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    AST_CAP_NEEDS_EN: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        nib_fall && en_n_s && !line_fall |=> !cap_valid_q && $stable(cap_cnt_q))
        else $error("capture while disabled");
    AST_CARRY_AFTER_20: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        cap_req && cap_cnt_q == NIB_LAST && !line_fall |=> !o_carry_n)
        else $error("carry not low after twenty nibbles");
    AST_NO_CAP_FULL: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !o_carry_n && !line_fall |=> !cap_valid_q && $stable(nib_q))
        else $error("capture while row full");
    AST_REARM: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        line_fall |=> o_carry_n && cap_cnt_q == ($past(cap_req) ? 5'h01 : 5'h00))
        else $error("line strobe did not rearm");
    AST_LINE_LATCH: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        line_fall |=> line_q == $past(row_q))
        else $error("line latch missed row");
    AST_BLANK: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !blank_n_s |=> o_column_drive[1:0] == level_sel_pos)
        else $error("blank not forcing first level");
    AST_PHASE_LOW: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        blank_n_s && !phase_s2_q && !line_q[0] |=> o_column_drive[1:0] == level_nonsel_pos)
        else $error("wrong non-selected level, phase low");
    AST_PHASE_HIGH: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        blank_n_s && phase_s2_q && line_q[0] |=> o_column_drive[1:0] == level_sel_neg)
        else $error("wrong selected level, phase high");
endmodule
`default_nettype wire

/* tb/lcd_ctrl_model.sv */
// controller model that sends pixel nibbles and line strobes to the driver
`default_nettype none
module lcd_ctrl_model
    import col_drv_pkg::*;
#(
    parameter int HALF = 8
)
(
    input wire logic i_clk_sys,
    output logic o_line_strobe,
    output logic o_nibble_strobe,
    output logic [NIB_W-1:0] o_pixel_nibble
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle levels at time zero
    initial begin
        o_line_strobe = 1'b0;
        o_nibble_strobe = 1'b0;
        o_pixel_nibble = '0;
    end

    // one nibble, strobe high then falling, data held past the fall
    task automatic send_nibble(input logic [NIB_W-1:0] d);
        o_pixel_nibble = d;
        o_nibble_strobe = 1'b1;
        repeat (HALF) @(negedge i_clk_sys);
        o_nibble_strobe = 1'b0;
        repeat (HALF) @(negedge i_clk_sys);
        o_pixel_nibble = ~d; // hold over, stale value not kept
    endtask

    // one line strobe pulse
    task automatic send_line();
        o_line_strobe = 1'b1;
        repeat (HALF) @(negedge i_clk_sys);
        o_line_strobe = 1'b0;
        repeat (HALF) @(negedge i_clk_sys);
    endtask
endmodule
`default_nettype wire

/* tb/lcd_column_driver_80ch_tb_top.sv */
// self-checking bench for the 80-column lcd driver
`default_nettype none
module lcd_column_driver_80ch_tb_top
    import col_drv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_clk_sys, i_rst_n, line_stb, nib_stb, fill_dir, en_n, blank_n, ac_phase;
    logic [NIB_W-1:0] nib;
    logic carry_n, nib_ready;
    logic [2*NUM_COLS-1:0] drive;
    int err_count, tests_run, cycles;

    ////////////////////////////////////////////////////////////////
    // clock, instances
    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end

    lcd_column_driver_80ch DUT (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
        .i_line_strobe(line_stb), .i_nibble_strobe(nib_stb), .i_pixel_nibble(nib),
        .i_fill_direction(fill_dir), .i_enable_n(en_n), .i_blank_n(blank_n),
        .i_ac_phase(ac_phase), .o_carry_n(carry_n), .o_nib_ready(nib_ready),
        .o_column_drive(drive));

    lcd_ctrl_model u_ctrl (.i_clk_sys(i_clk_sys), .o_line_strobe(line_stb),
        .o_nibble_strobe(nib_stb), .o_pixel_nibble(nib));

    ////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic check(input logic [159:0] seen, input logic [159:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask

    // expected column codes from row bits, phase and blank
    function automatic logic [159:0] exp_drive(input logic [79:0] row, input logic ph,
                                               input logic bl);
        logic [159:0] e;
        level_type lv;
        for (int c = 0; c < NUM_COLS; c++) begin
            if (!bl) lv = level_sel_pos;
            else if (ph) lv = row[c] ? level_sel_neg : level_nonsel_neg;
            else lv = row[c] ? level_sel_pos : level_nonsel_pos;
            e[2*c +: 2] = lv;
        end
        return e;
    endfunction

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        check(160'(carry_n), 160'h1, "carry high after reset");
        check(drive, exp_drive(80'h0, 1'b0, 1'b1), "drive idle after reset");
        check(160'(nib_ready), 160'h1, "buffer ready when empty");
        $display("test reset done");
    endtask

    // disabled nibbles, full line, refused extra nibble, then level checks
    task automatic t_fill(input logic dir, input logic [3:0] seed);
        logic [79:0] row;
        logic [3:0] d;
        row = '0;
        fill_dir = dir;
        en_n = 1'b1;
        for (int k = 0; k < 3; k++) u_ctrl.send_nibble(4'hf);
        en_n = 1'b0;
        for (int k = 0; k < NIBS_PER_LINE; k++) begin
            d = 4'(k) ^ seed;
            u_ctrl.send_nibble(d);
            for (int b = 0; b < NIB_W; b++) row[dir ? 79 - 4*k - b : 4*k + b] = d[b];
        end
        wait_n(8);
        check(160'(carry_n), 160'h0, "carry low after twenty nibbles");
        u_ctrl.send_nibble(~seed);
        u_ctrl.send_line();
        wait_n(8);
        check(160'(carry_n), 160'h1, "carry rearmed by line strobe");
        for (int ph = 0; ph < 2; ph++) begin
            ac_phase = ph[0];
            wait_n(6);
            check(drive, exp_drive(row, ph[0], 1'b1), "levels");
        end
        blank_n = 1'b0;
        wait_n(6);
        check(drive, exp_drive(row, 1'b1, 1'b0), "blank forces first level");
        blank_n = 1'b1;
        ac_phase = 1'b0;
        wait_n(6);
        check(drive, exp_drive(row, 1'b0, 1'b1), "levels back after blank");
        $display("test fill dir %0d done", dir);
    endtask

    ////////////////////////////////////////////////////////////////
    // timeout guard
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            $display("[FAIL] %0t timeout", $time);
            wrap_up();
        end
    end

    // main sequence
    initial begin
        err_count = 0;
        tests_run = 0;
        cycles = 0;
        i_rst_n = 1'b0;
        fill_dir = 1'b0;
        en_n = 1'b0;
        blank_n = 1'b1;
        ac_phase = 1'b0;
        wait_n(5);
        i_rst_n = 1'b1;
        wait_n(3);
        t_reset();
        t_fill(1'b0, 4'h5);
        t_fill(1'b1, 4'ha);
        wrap_up();
    end
endmodule
`default_nettype wire
